// file: core/pbmc_ctrl.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Negotiation enabled: speed, duplex report results
// - Negotiation disabled: link uses written speed, duplex
// - Speed bit: 0 is 10, 1 is 100
// - Negotiation enable is read-write, resets to one
// - Power down stops transceiver, oscillator keeps running
// - Reserved bit written zero, read ignored
// - Restart bit holds until negotiation starts, clears; here a control write without it, or negotiation off, also clears it
// - Clearing restart bit never disturbs running negotiation
// - Manual duplex applies only while negotiation off
module pbmc_ctrl
	import pbmc_pkg::*;
(
	input  wire logic        clk,           // 125 MHz clock
	input  wire logic        nrst,          // Async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	input  wire pbmc_an_t    an_status,     // Negotiation engine status, same clock
	output logic             an_start,      // One-cycle pulse: begin negotiation
	output logic             an_enable,     // Negotiation enable level
	output pbmc_link_t       link_cfg       // Settings applied to the transceiver
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	logic       speed_q;     // Written speed
	logic       anen_q;      // Negotiation enable
	logic       pdown_q;     // Power down
	logic       duplex_q;    // Written duplex
	logic       restart_q;   // Pending restart request
	logic       aw_hold_q;   // Write address captured
	logic       w_hold_q;    // Write data captured
	logic [7:0] awaddr_q;    // Captured write address
	logic [31:0] wdata_q;    // Captured write data
	logic [3:0] wstrb_q;     // Captured strobes
	logic       wr_fire;     // Both halves present, response free
	logic       ctrl_wr;     // Write hits control register
	logic [15:0] ctrl_rd;    // Control word as read back
	logic       start_pend;  // Restart may launch now

	////////////////////////////////////////////////////////////////////////////////
	// Write channels: address and data accepted in either order

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready  = !w_hold_q;
	assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign ctrl_wr       = wr_fire && (awaddr_q == PBMC_CTRL_ADDR) && wstrb_q[1];

	// Capture address and data halves
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Write response; every address other than the control register gets SLVERR
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PBMC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q == PBMC_CTRL_ADDR) ? PBMC_RESP_OKAY : PBMC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control fields; all live in byte lane 1

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			speed_q  <= PBMC_SPEED_RST;
			anen_q   <= PBMC_ANEN_RST;
			pdown_q  <= PBMC_PDOWN_RST;
			duplex_q <= PBMC_DUPLEX_RST;
		end else if (ctrl_wr) begin
			speed_q  <= wdata_q[PBMC_SPEED_BIT];
			anen_q   <= wdata_q[PBMC_ANEN_BIT];
			pdown_q  <= wdata_q[PBMC_PDOWN_BIT];
			duplex_q <= wdata_q[PBMC_DUPLEX_BIT];
			// Reserved bit is simply not stored
		end
	end

	// Restart request: held until the engine is free to begin, then cleared.
	// A software write of zero while it is pending withdraws it, but never
	// touches a negotiation already running.
	assign start_pend = restart_q && anen_q && !an_status.busy && !pdown_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			restart_q <= 1'b0;
		end else if (ctrl_wr && wdata_q[PBMC_RESTART_BIT] && wdata_q[PBMC_ANEN_BIT]) begin
			restart_q <= 1'b1;
		end else if (start_pend) begin
			restart_q <= 1'b0;
		end else if (ctrl_wr) begin
			restart_q <= 1'b0;
		end else if (!anen_q) begin
			restart_q <= 1'b0;
		end
	end

	// Start pulse to the negotiation engine
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			an_start <= 1'b0;
		end else begin
			an_start <= start_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link settings handed to the transceiver

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link_cfg  <= '{speed_100: PBMC_SPEED_RST, full_dup: PBMC_DUPLEX_RST,
				pdown: PBMC_PDOWN_RST};
			an_enable <= PBMC_ANEN_RST;
		end else begin
			an_enable      <= anen_q;
			link_cfg.pdown <= pdown_q;
			if (anen_q) begin
				link_cfg.speed_100 <= an_status.speed_100;
				link_cfg.full_dup  <= an_status.full_dup;
			end else begin
				link_cfg.speed_100 <= speed_q;
				link_cfg.full_dup  <= duplex_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// Readback: speed and duplex report negotiation result when enabled
	always_comb begin
		ctrl_rd                   = 16'h0000;
		ctrl_rd[PBMC_SPEED_BIT]   = anen_q ? an_status.speed_100 : speed_q;
		ctrl_rd[PBMC_ANEN_BIT]    = anen_q;
		ctrl_rd[PBMC_PDOWN_BIT]   = pdown_q;
		ctrl_rd[PBMC_RSVD_BIT]    = 1'b0;
		ctrl_rd[PBMC_RESTART_BIT] = restart_q;
		ctrl_rd[PBMC_DUPLEX_BIT]  = anen_q ? an_status.full_dup : duplex_q;
	end

	assign s_axi_arready = !s_axi_rvalid;

	// One read outstanding; data registered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= PBMC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= PBMC_RESP_OKAY;
			unique case (s_axi_araddr)
				PBMC_CTRL_ADDR: begin
					s_axi_rdata <= {16'h0000, ctrl_rd};
				end
				PBMC_STAT_ADDR: begin
					s_axi_rdata <= {29'h0, an_status.busy, restart_q, anen_q};
				end
				PBMC_ANRES_ADDR: begin
					s_axi_rdata <= {29'h0, pdown_q, an_status.speed_100, an_status.full_dup};
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= PBMC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_anen_reset: assert property (@(posedge clk) $rose(nrst) |-> anen_q)
		else $error("Negotiation enable not one after reset");

	a_forced_speed: assert property (@(posedge clk) disable iff (!nrst)
		!anen_q && $stable(anen_q) && $stable(speed_q) |=> link_cfg.speed_100 == $past(speed_q))
		else $error("Forced speed not applied");

	a_forced_duplex: assert property (@(posedge clk) disable iff (!nrst)
		!anen_q && $stable(anen_q) |=> link_cfg.full_dup == $past(duplex_q))
		else $error("Forced duplex not applied");

	a_an_result: assert property (@(posedge clk) disable iff (!nrst)
		anen_q |=> link_cfg.speed_100 == $past(an_status.speed_100))
		else $error("Negotiated speed not applied");

	a_pdown_follow: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_wr |=> ##1 link_cfg.pdown == $past(wdata_q[PBMC_PDOWN_BIT], 2))
		else $error("Power down not applied");

	a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_rd[PBMC_RSVD_BIT] == 1'b0)
		else $error("Reserved bit reads one");

	a_restart_hold: assert property (@(posedge clk) disable iff (!nrst)
		restart_q && !start_pend && !ctrl_wr && anen_q |=> restart_q)
		else $error("Restart cleared before start");

	// Power down taken from the written word: the stored bit updates at the same edge
	a_restart_start: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_wr && wdata_q[PBMC_RESTART_BIT] && wdata_q[PBMC_ANEN_BIT]
		&& !wdata_q[PBMC_PDOWN_BIT] ##1 (!an_status.busy && !ctrl_wr)[*2] |-> an_start)
		else $error("Restart did not launch negotiation");

	// Withdrawing the restart bit keeps negotiation enabled and launches nothing
	a_clear_nodist: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_wr && !wdata_q[PBMC_RESTART_BIT] && wdata_q[PBMC_ANEN_BIT]
		|=> ##1 (an_enable && !an_start))
		else $error("Clearing restart disturbed negotiation");

	c_restart: cover property (@(posedge clk) disable iff (!nrst) an_start);
	c_forced: cover property (@(posedge clk) disable iff (!nrst) ctrl_wr && !wdata_q[PBMC_ANEN_BIT]);
	c_pdown: cover property (@(posedge clk) disable iff (!nrst) link_cfg.pdown);
	c_bad_addr: cover property (@(posedge clk) disable iff (!nrst)
		s_axi_rvalid && s_axi_rresp == PBMC_RESP_SLVERR);

endmodule

// file: core/pbmc_pkg.sv
package pbmc_pkg;

	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0]  PBMC_CTRL_ADDR   = 8'h00; // Basic control register
	localparam logic [7:0]  PBMC_STAT_ADDR   = 8'h04; // Negotiation busy, pending restart and enable
	localparam logic [7:0]  PBMC_ANRES_ADDR  = 8'h08; // Power down and negotiation result inputs shadow (read only)

	// Field positions in the basic control register
	localparam int          PBMC_SPEED_BIT   = 13;    // 1 = 100 Mbps, 0 = 10 Mbps
	localparam int          PBMC_ANEN_BIT    = 12;    // Auto-negotiation enable
	localparam int          PBMC_PDOWN_BIT   = 11;    // Transceiver power down
	localparam int          PBMC_RSVD_BIT    = 10;    // Reserved, reads zero
	localparam int          PBMC_RESTART_BIT = 9;     // Restart negotiation, self clearing
	localparam int          PBMC_DUPLEX_BIT  = 8;     // 1 = full duplex

	// Reset values of the stored fields
	localparam logic        PBMC_SPEED_RST   = 1'b1;
	localparam logic        PBMC_ANEN_RST    = 1'b1;
	localparam logic        PBMC_PDOWN_RST   = 1'b0;
	localparam logic        PBMC_DUPLEX_RST  = 1'b0;

	// AXI response codes
	localparam logic [1:0]  PBMC_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  PBMC_RESP_SLVERR = 2'b10;

	// Link settings handed to the transceiver
	typedef struct packed {
		logic speed_100; // 1 = 100 Mbps
		logic full_dup;  // 1 = full duplex
		logic pdown;     // Transceiver powered down
	} pbmc_link_t;

	// Negotiation engine status
	typedef struct packed {
		logic busy;      // Negotiation in progress
		logic speed_100; // Selected speed
		logic full_dup;  // Selected duplex
	} pbmc_an_t;

endpackage

// file: verification/pbmc_tb.sv
`timescale 1ns/1ns
module tb
	import pbmc_pkg::*;
;
	logic             clk, nrst;                      // Clock, active-low reset
	logic [7:0]       s_axi_awaddr, s_axi_araddr;     // Bus addresses
	logic             s_axi_awvalid, s_axi_wvalid;    // Write request valids
	logic             s_axi_bready, s_axi_arvalid;    // Response ready, read valid
	logic             s_axi_rready;                   // Read data ready
	logic [31:0]      s_axi_wdata, s_axi_rdata;       // Bus data
	logic [3:0]       s_axi_wstrb;                    // Byte strobes
	logic             s_axi_awready, s_axi_wready;    // Slave readies
	logic             s_axi_arready, s_axi_bvalid;    // Slave readies, valid
	logic             s_axi_rvalid;                   // Read valid
	logic [1:0]       s_axi_bresp, s_axi_rresp;       // Response codes
	pbmc_an_t         an_status;                      // Engine status driven here
	logic             an_start, an_enable;            // Engine controls
	pbmc_link_t       link_cfg;                       // Transceiver settings
	int               err_count, total_checks, starts; // Counters
	logic             m_spd, m_en, m_pd, m_dup;       // Model of the stored fields
	logic [31:0]      rd_d;                           // Last read data
	logic [1:0]       rsp;                            // Last response code

	pbmc_ctrl dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .an_status, .an_start, .an_enable, .link_cfg);

	////////////////////////////////////////////////////////////////////////////////
	// Clock, pulse counter sampled mid-cycle to stay clear of edge races
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge clk) begin
		if (an_start === 1'b1) starts++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (err_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Handshakes sampled at negedge, acted on at the following rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		int   n;
		b = 1'b0;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b && n < 50) begin
			@(negedge clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid & s_axi_bready;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			n++;
		end
		if (!b) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar, r;
		int   n;
		r = 1'b0;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		while (!r && n < 50) begin
			@(negedge clk);
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid & s_axi_rready;
			rd_d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
			n++;
		end
		if (!r) begin
			err_count++;
			final_report();
		end
	endtask
	// Control write through the model; reserved bit always written zero
	task automatic wc(input logic s, e, p, d, rs);
		m_spd = s; m_en = e; m_pd = p; m_dup = d;
		wr(PBMC_CTRL_ADDR, {18'h0, s, e, p, 1'b0, rs, d, 8'h0});
		chk(rsp, PBMC_RESP_OKAY);
		repeat (2) @(posedge clk);
	endtask
	// Expected control read; reserved bit left out of the compare
	task automatic rc(input logic rs);
		logic s, d;
		s = m_en ? an_status.speed_100 : m_spd;
		d = m_en ? an_status.full_dup : m_dup;
		rd(PBMC_CTRL_ADDR);
		chk(rd_d & 32'h3b00, {18'h0, s, m_en, m_pd, 1'b0, rs, d, 8'h0});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0; s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0;
		s_axi_wstrb = 4'hf; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; an_status = '0;
		err_count = 0; total_checks = 0; starts = 0;
		m_spd = PBMC_SPEED_RST; m_en = PBMC_ANEN_RST; m_pd = 1'b0; m_dup = 1'b0;
		void'($urandom(43));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(an_enable, 1'b1);
		rc(1'b0);
		// Negotiated results shown while enabled
		for (int i = 0; i < 4; i++) begin
			an_status <= pbmc_an_t'({1'b0, 2'($urandom())});
			@(posedge clk);
			rc(1'b0);
		end
		// Forced speed and duplex while disabled, every combination
		for (int i = 0; i < 4; i++) begin
			an_status <= pbmc_an_t'({1'b0, 2'($urandom())});
			wc(i[1], 1'b0, 1'b0, i[0], 1'b0);
			chk(link_cfg, {i[1], i[0], 1'b0});
			chk(an_enable, 1'b0);
			rc(1'b0);
		end
		// Power down and back
		wc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		chk(link_cfg.pdown, 1'b1);
		rc(1'b0);
		wc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		chk(link_cfg.pdown, 1'b0);
		// Restart held while the engine is busy, launched once it idles
		an_status <= '{busy: 1'b1, speed_100: 1'b1, full_dup: 1'b0};
		wc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		repeat (5) @(posedge clk);
		chk(starts, 0);
		rc(1'b1);
		rd(PBMC_STAT_ADDR);
		chk(rsp, PBMC_RESP_OKAY);
		chk(rd_d, {29'h0, 1'b1, 1'b1, m_en});
		an_status.busy <= 1'b0;
		for (int n = 0; n < 20 && starts == 0; n++) @(posedge clk);
		chk(starts, 1);
		rc(1'b0);
		// Clearing the bit during a run leaves the engine alone
		an_status.busy <= 1'b1;
		wc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		chk(starts, 1);
		chk(an_enable, 1'b1);
		// Restart waits for power-up as well as an idle engine
		an_status.busy <= 1'b0;
		wc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		repeat (5) @(posedge clk);
		chk(starts, 1);
		rd(PBMC_ANRES_ADDR);
		chk(rd_d, {29'h0, m_pd, an_status.speed_100, an_status.full_dup});
		rc(1'b1);
		wc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		for (int n = 0; n < 20 && starts < 2; n++) @(posedge clk);
		chk(starts, 2);
		rc(1'b0);
		// Unmapped and read-only places refuse and change nothing
		wr(8'h0c, 32'h0000_ffff);
		chk(rsp, PBMC_RESP_SLVERR);
		wr(PBMC_STAT_ADDR, 32'h0000_ffff);
		chk(rsp, PBMC_RESP_SLVERR);
		rd(8'h0c);
		chk(rsp, PBMC_RESP_SLVERR);
		rc(1'b0);
		final_report();
	end
endmodule
